// file: pkg/rwlpc_pkg.sv
// Purpose: constants and types for the reset, watchdog and low-power control block
// Assumes: one 100 MHz bus clock, byte-wide register port with 16-bit addresses
// Notes:   register offsets, control bit positions, pin and misc reset values and reset timing counts live here; the watchdog timeout is a top parameter
`default_nettype none
package rwlpc_pkg;
    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned POR_DELAY     = 4064;    // oscillator settling, bus cycles
    localparam int unsigned RST_HOLD      = 4;       // internal reset stretch for pulse sources
    localparam int unsigned DIV_FAST      = 5;
    localparam int unsigned DIV_SLOW      = 40;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [15:0] WDOG_ADDR     = 16'h1FF0;
    localparam logic [15:0] MISC_ADDR     = 16'h0021;
    localparam logic [15:0] STAT_ADDR     = 16'h0022;
    localparam int unsigned WDOG_CLR_BIT  = 0;
    localparam int unsigned SPEED_BIT     = 0;
    localparam logic [7:0]  MISC_RST      = 8'h00;
    // ----------------------------------------------------------------
    // illegal fetch ranges
    // ----------------------------------------------------------------
    localparam logic [15:0] IO_LO         = 16'h0000;
    localparam logic [15:0] IO_HI         = 16'h002F;
    localparam logic [15:0] UNIMP_LO      = 16'h0130;
    localparam logic [15:0] UNIMP_HI      = 16'h0AFF;
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic osc_active;
        logic ext_rst_n;
        logic irq_n;
        logic irq_at_test_v;
        logic mode_select_pin_b;
        logic mode_select_pin_d;
    } rwlpc_pins_t;
    localparam rwlpc_pins_t PINS_RST = 6'h18;  // osc off, reset/irq released, straps low

    typedef enum logic [3:0] {
        ST_RUN  = 4'h1,
        ST_WAIT = 4'h2,
        ST_STOP = 4'h4
    } rwlpc_state_t;
endpackage
`default_nettype wire

// file: design/rwlpc_top.sv
// Purpose: reset merge, watchdog, illegal fetch detect, mode select, stop/wait control
// Assumes: pins arrive asynchronously; cpu strobes and register port are on ref_clk
// Notes:   oscillator and core timer live outside; this block only sends them control
//
// Function
// - reset pin low holds internal reset
// - reset sequence starts first edge after release
// - mode changes only when external/watchdog reset ends
// - power-up holds reset 4064 cycles after oscillator
// - reset stays while any other source active
// - reset pin driven low during power-up reset
// - unfed watchdog raises internal reset on timeout
// - watchdog present only by build option
// - writing zero to clear bit restarts watchdog
// - watchdog location reads user data only
// - watchdog keeps counting in wait
// - watchdog frozen while stopped
// - reset out of stop clears, holds watchdog
// - interrupt out of stop counts settling cycles
// - fetch from illegal range raises reset
// - self-check mode on test voltage straps
// - stop turns oscillator off, halts processing
// - stop entry clears timer flags and mask
// - only interrupt or reset leaves stop
// - wait halts cpu, any interrupt exits
// - wait and speed bit select divide-by-40
// - interrupt exit from wait restores divider
`timescale 1ns/1ps
`default_nettype none
module rwlpc_top
    import rwlpc_pkg::*;
#(
    parameter bit          WDOG_PRESENT  = 1'b1,
    parameter int unsigned WDOG_TIMEOUT  = 65536,
    parameter logic [7:0]  USER_VEC_BYTE = 8'h00   // value arbitrary
) (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire rwlpc_pins_t pins,
    input  wire logic        fetch_valid,
    input  wire logic [15:0] fetch_addr,
    input  wire logic        stop_exec,
    input  wire logic        wait_exec,
    input  wire logic        int_req,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_we,
    input  wire logic        reg_re,
    output logic [7:0]       reg_rdata,
    output logic             int_rst,
    output logic             ext_rst_o,
    output logic             ext_rst_oe,
    output logic             self_check_mode,
    output logic             osc_enable,
    output logic             div40_sel,
    output logic             cpu_clk_en,
    output logic             cpu_halt,
    output logic             ctimer_clr,
    output logic             ccr_i_clr
);
    localparam int WW = $clog2(WDOG_TIMEOUT + 1);
    localparam logic [WW-1:0] WDOG_LAST = WW'(WDOG_TIMEOUT - 1);
    localparam logic [11:0]   POR_LAST  = 12'(POR_DELAY - 1);
    localparam logic [5:0]    DIV_F_END = 6'(DIV_FAST - 1);
    localparam logic [5:0]    DIV_S_END = 6'(DIV_SLOW - 1);
    localparam logic [2:0]    HOLD_INIT = 3'(RST_HOLD);

    function automatic logic is_illegal(input logic [15:0] a);
        is_illegal = (a >= IO_LO && a <= IO_HI) || (a >= UNIMP_LO && a <= UNIMP_HI);
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    rwlpc_pins_t s1_q, s2_q, s3_q, pin_q;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_q  <= PINS_RST;
            s2_q  <= PINS_RST;
            s3_q  <= PINS_RST;
            pin_q <= PINS_RST;
        end else begin
            s1_q  <= pins;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            // a bit moves only once stages two and three agree, so one noisy sample is dropped
            pin_q <= (pin_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
        end
    end

    // ----------------------------------------------------------------
    // state and reset sources
    // ----------------------------------------------------------------
    rwlpc_state_t state_q, state_d;
    logic [11:0]  por_cnt_q;
    logic         por_rst_q, por_busy_q, por_done;
    logic [2:0]   wdog_hold_q, ill_hold_q;
    logic [WW-1:0] wdog_cnt_q;
    logic         wdog_fire, wdog_feed, ill_fetch, ext_act, ext_prev_q;
    logic         int_rst_d, stop_rst_exit, stop_irq_exit, mode_sample;
    logic [7:0]   misc_q;
    logic         int_rst_q;

    assign ext_act       = !pin_q.ext_rst_n;
    assign ill_fetch     = fetch_valid && is_illegal(fetch_addr) && state_q == ST_RUN;
    assign int_rst_d     = por_rst_q || ext_act || wdog_hold_q != 3'h0 || ill_hold_q != 3'h0;
    assign stop_rst_exit = state_q == ST_STOP && ext_act;
    assign stop_irq_exit = state_q == ST_STOP && !ext_act && !pin_q.irq_n;
    assign por_done      = por_busy_q && pin_q.osc_active && por_cnt_q == POR_LAST;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (!int_rst_q && stop_exec) begin
                    state_d = ST_STOP;
                end else if (!int_rst_q && wait_exec) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (int_rst_d || int_req || !pin_q.irq_n) begin
                    state_d = ST_RUN;
                end
            end
            ST_STOP: begin
                if (stop_rst_exit || stop_irq_exit) begin
                    state_d = ST_RUN;
                end
            end
            default: state_d = ST_RUN;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // power-up / stop recovery settling delay
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            por_cnt_q  <= 12'h000;
            por_busy_q <= 1'b1;
            por_rst_q  <= 1'b1;
        end else if (stop_rst_exit || stop_irq_exit) begin
            // oscillator restarts, so settling starts over in both cases
            por_cnt_q  <= 12'h000;
            por_busy_q <= 1'b1;
            por_rst_q  <= stop_rst_exit;
        end else if (por_done) begin
            por_busy_q <= 1'b0;
            por_rst_q  <= 1'b0;
        end else if (por_busy_q && pin_q.osc_active && state_q != ST_STOP) begin
            por_cnt_q  <= por_cnt_q + 12'h001;
        end
    end

    // pulse sources stretched so the cpu sees a clean reset
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wdog_hold_q <= 3'h0;
            ill_hold_q  <= 3'h0;
        end else begin
            if (wdog_fire) begin
                wdog_hold_q <= HOLD_INIT;
            end else if (wdog_hold_q != 3'h0) begin
                wdog_hold_q <= wdog_hold_q - 3'h1;
            end
            if (ill_fetch) begin
                ill_hold_q <= HOLD_INIT;
            end else if (ill_hold_q != 3'h0) begin
                ill_hold_q <= ill_hold_q - 3'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // watchdog
    // ----------------------------------------------------------------
    assign wdog_feed = reg_we && reg_addr == WDOG_ADDR && !reg_wdata[WDOG_CLR_BIT];
    assign wdog_fire = WDOG_PRESENT && state_q != ST_STOP && !int_rst_q
                       && !wdog_feed && wdog_cnt_q == WDOG_LAST;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wdog_cnt_q <= '0;
        end else if (!WDOG_PRESENT || wdog_feed || int_rst_q || wdog_fire) begin
            wdog_cnt_q <= '0;
        end else if (state_q != ST_STOP) begin
            // counts in run, wait and interrupt-led stop recovery; frozen while stopped
            wdog_cnt_q <= wdog_cnt_q + WW'(1);
        end
    end

    // ----------------------------------------------------------------
    // operating mode
    // ----------------------------------------------------------------
    // only the end of a pin or watchdog reset samples the straps
    assign mode_sample = (ext_prev_q && !ext_act) || wdog_hold_q == 3'h1;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_prev_q      <= 1'b0;
            self_check_mode <= 1'b0;
        end else begin
            ext_prev_q <= ext_act;
            if (mode_sample) begin
                self_check_mode <= pin_q.irq_at_test_v && pin_q.mode_select_pin_b
                                   && !pin_q.mode_select_pin_d;
            end
        end
    end

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            misc_q <= MISC_RST;
        end else if (reg_we && reg_addr == MISC_ADDR) begin
            misc_q <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_re) begin
            case (reg_addr)
                WDOG_ADDR: reg_rdata <= USER_VEC_BYTE;
                MISC_ADDR: reg_rdata <= misc_q;
                STAT_ADDR: reg_rdata <= {2'h0, self_check_mode, por_busy_q, int_rst_q, state_q[2:0]};
                default:   reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // outputs and divider
    // ----------------------------------------------------------------
    logic [5:0] div_cnt_q;
    assign int_rst = int_rst_q;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            int_rst_q  <= 1'b1;
            ext_rst_o  <= 1'b0;
            ext_rst_oe <= 1'b1;
            osc_enable <= 1'b1;
            cpu_halt   <= 1'b1;
            div40_sel  <= 1'b0;
        end else begin
            int_rst_q  <= int_rst_d;
            ext_rst_o  <= 1'b0;
            ext_rst_oe <= por_rst_q;
            osc_enable <= state_d != ST_STOP;
            cpu_halt   <= state_d != ST_RUN || por_busy_q || int_rst_d;
            // speed bit stays untouched by wait, so leaving wait restores the old rate
            div40_sel  <= state_d == ST_WAIT || misc_q[SPEED_BIT];
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctimer_clr <= 1'b0;
            ccr_i_clr  <= 1'b0;
        end else begin
            ctimer_clr <= state_q == ST_RUN && state_d == ST_STOP;
            ccr_i_clr  <= state_q == ST_RUN && state_d != ST_RUN;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt_q  <= 6'h00;
            cpu_clk_en <= 1'b0;
        end else if (state_q == ST_STOP) begin
            cpu_clk_en <= 1'b0;
        end else if (div_cnt_q >= (div40_sel ? DIV_S_END : DIV_F_END)) begin
            div_cnt_q  <= 6'h00;
            cpu_clk_en <= 1'b1;
        end else begin
            div_cnt_q  <= div_cnt_q + 6'h01;
            cpu_clk_en <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_pin_reset_holds: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ext_act |=> int_rst_q) else $error("pin reset not seen internally");
    a_por_drives_pin: assert property (@(posedge ref_clk) disable iff (sys_rst)
        por_rst_q |=> ext_rst_oe && !ext_rst_o) else $error("pin not driven in power-up");
    a_por_length: assert property (@(posedge ref_clk) disable iff (sys_rst)
        por_busy_q && por_cnt_q == 12'h000 && pin_q.osc_active && state_q != ST_STOP
        |=> por_busy_q) else $error("settling ended early");
    a_wdog_times_out: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wdog_fire |=> wdog_hold_q == HOLD_INIT ##1 int_rst_q) else $error("timeout gave no reset");
    a_wdog_absent: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !WDOG_PRESENT |-> wdog_hold_q == 3'h0) else $error("watchdog reset while absent");
    a_wdog_feed: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wdog_feed |=> wdog_cnt_q == '0) else $error("feed did not restart count");
    a_wdog_stop_freeze: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_q == ST_STOP && !int_rst_q |=> $stable(wdog_cnt_q)) else $error("count moved in stop");
    a_wdog_wait_runs: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_q == ST_WAIT && !int_rst_q && !wdog_feed && !wdog_fire && WDOG_PRESENT
        |=> wdog_cnt_q == $past(wdog_cnt_q) + WW'(1)) else $error("count stalled in wait");
    a_illegal_fetch: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ill_fetch |=> ##1 int_rst_q [*3]) else $error("illegal fetch gave no reset");
    a_mode_only_sampled: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !mode_sample |=> $stable(self_check_mode)) else $error("mode changed without sample");
    a_stop_entry_clears: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_q == ST_RUN && state_d == ST_STOP |=> ctimer_clr && ccr_i_clr && !osc_enable)
        else $error("stop entry side effects missing");
    a_wait_div_slow: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_q == ST_WAIT ##1 state_q == ST_WAIT |-> div40_sel) else $error("wait not at slow divider");

    // recovery, low-power exits and the shared read location
    a_wdog_held_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
        por_rst_q && int_rst_q |=> wdog_cnt_q == '0) else $error("count moved during reset recovery");
    a_wdog_irq_recovery: assert property (@(posedge ref_clk) disable iff (sys_rst)
        por_busy_q && !por_rst_q && !int_rst_q && state_q == ST_RUN && WDOG_PRESENT && !wdog_feed && !wdog_fire
        |=> wdog_cnt_q == $past(wdog_cnt_q) + WW'(1)) else $error("count waited for settling");
    a_stop_holds: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_q == ST_STOP && pin_q.irq_n && !ext_act |=> state_q == ST_STOP && !osc_enable)
        else $error("stop left without interrupt or reset");
    a_stop_osc_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_q == ST_STOP ##1 state_q == ST_STOP |-> !osc_enable && !cpu_clk_en)
        else $error("clock ran while stopped");
    a_wait_exit_int: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_q == ST_WAIT && int_req |=> state_q == ST_RUN) else $error("interrupt did not end wait");
    a_wait_div_restore: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_q == ST_WAIT && state_d == ST_RUN |=> div40_sel == $past(misc_q[SPEED_BIT]))
        else $error("divider not restored after wait");
    a_read_user_byte: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_re && reg_addr == WDOG_ADDR |=> reg_rdata == USER_VEC_BYTE) else $error("watchdog location read wrong");
endmodule // rwlpc_top
`default_nettype wire

// file: dv/rwlpc_board.sv
// Purpose: board side of the block: reset button, pull-up on the reset pin, oscillator, irq pin and mode straps
// Assumes: oscillator runs a fixed number of cycles after it is enabled, stops at once when disabled
// Notes:   the reset pin is open drain with a pull-up, so the board button and the block both pull it low
`timescale 1ns/1ps
`default_nettype none
module rwlpc_board
    import rwlpc_pkg::*;
#(
    parameter int unsigned OSC_START = 8
) (
    input  wire logic  ref_clk,
    input  wire logic  osc_enable,
    input  wire logic  ext_rst_oe,
    input  wire logic  ext_rst_o,
    input  wire logic  rst_btn,
    input  wire logic  irq_btn,
    input  wire logic  test_v,
    input  wire logic  strap_b,
    input  wire logic  strap_d,
    output wire rwlpc_pins_t pins
);
    // ----------------------------------------------------------------
    // oscillator start-up
    // ----------------------------------------------------------------
    int unsigned osc_cnt_q = 0;
    always @(posedge ref_clk or negedge osc_enable) begin
        if (!osc_enable) begin
            osc_cnt_q <= 0;
        end else if (osc_cnt_q < OSC_START) begin
            osc_cnt_q <= osc_cnt_q + 1;
        end
    end
    // ----------------------------------------------------------------
    // pin levels
    // ----------------------------------------------------------------
    // pull-up wins only when nobody pulls the reset pin low
    assign pins.osc_active        = (osc_cnt_q >= OSC_START);
    assign pins.ext_rst_n         = !(rst_btn || (ext_rst_oe && !ext_rst_o));
    assign pins.irq_n             = !irq_btn;
    assign pins.irq_at_test_v     = test_v;
    assign pins.mode_select_pin_b = strap_b;
    assign pins.mode_select_pin_d = strap_d;
endmodule // rwlpc_board
`default_nettype wire

// file: dv/test_rwlpc_top.sv
// Purpose: self-checking bench for the reset, watchdog and low-power control block
// Assumes: watchdog timeout shortened to 64 cycles; settling count kept at full length
// Notes:   checks are taken 1 ns after a rising edge, when registered outputs have landed
`timescale 1ns/1ps
`default_nettype none
module test_rwlpc_top;
    import rwlpc_pkg::*;
    localparam int unsigned TMO = 64;
    localparam logic [7:0]  UVB = 8'h5A;    // value arbitrary
    logic ref_clk = 1'b0, sys_rst = 1'b1, fetch_valid = 1'b0, stop_exec = 1'b0, wait_exec = 1'b0, int_req = 1'b0;
    logic reg_we = 1'b0, reg_re = 1'b0, rst_btn = 1'b0, irq_btn = 1'b0, test_v = 1'b0, strap_b = 1'b0, strap_d = 1'b0;
    logic [15:0] fetch_addr = 16'h0000, reg_addr = 16'h0000;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata;
    logic int_rst, ext_rst_o, ext_rst_oe, self_check_mode, osc_enable, div40_sel, cpu_clk_en, cpu_halt;
    logic ctimer_clr, ccr_i_clr;
    rwlpc_pins_t pins;
    int n_fail = 0, tests_run = 0, hits, clrs;
    logic [15:0] ill_a [7] = '{16'h0000, 16'h002F, 16'h0130, 16'h0AFF, 16'h0030, 16'h012F, 16'h0B00};
    logic        ill_e [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    always #5 ref_clk = ~ref_clk;
    rwlpc_top #(.WDOG_PRESENT(1'b1), .WDOG_TIMEOUT(TMO), .USER_VEC_BYTE(UVB)) u_rwlpc_top (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .pins(pins), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
        .stop_exec(stop_exec), .wait_exec(wait_exec), .int_req(int_req), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .int_rst(int_rst),
        .ext_rst_o(ext_rst_o), .ext_rst_oe(ext_rst_oe), .self_check_mode(self_check_mode),
        .osc_enable(osc_enable), .div40_sel(div40_sel), .cpu_clk_en(cpu_clk_en), .cpu_halt(cpu_halt),
        .ctimer_clr(ctimer_clr), .ccr_i_clr(ccr_i_clr));
    rwlpc_board u_rwlpc_board (
        .ref_clk(ref_clk), .osc_enable(osc_enable), .ext_rst_oe(ext_rst_oe), .ext_rst_o(ext_rst_o),
        .rst_btn(rst_btn), .irq_btn(irq_btn), .test_v(test_v), .strap_b(strap_b), .strap_d(strap_d),
        .pins(pins));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic look(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // counts cpu clock enables over n edges
    task automatic ticks(input int n, input logic [7:0] exp);
        int c;
        c = 0;
        repeat (n) begin
            look(1);
            c += int'(cpu_clk_en === 1'b1);
        end
        chk(8'(c), exp);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_we <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge ref_clk);
        reg_we <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_re <= 1'b1; reg_addr <= a;
        @(posedge ref_clk);
        reg_re <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    // waits a bounded span for the internal reset to reach a level
    task automatic wait_rst(input logic lvl, input int max);
        int i;
        i = 0;
        while (int_rst !== lvl && i < max) begin
            look(1);
            i++;
        end
        chk({7'h00, int_rst}, {7'h00, lvl});
    endtask
    // counts cycles of the reset and clear pulses just after an operation
    task automatic watch(input int n);
        hits = 0; clrs = 0;
        repeat (n) begin
            #1;
            hits += int'(int_rst === 1'b1 || ccr_i_clr === 1'b1 && !stop_exec);
            clrs += int'(ctimer_clr === 1'b1);
            @(posedge ref_clk);
        end
    endtask
    task automatic end_sim;
        if (n_fail == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #300_000;
        n_fail++;
        end_sim();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        look(4040);
        chk({5'h00, ext_rst_o, int_rst, ext_rst_oe}, 8'h03);
        wait_rst(1'b0, 200);
        chk({7'h00, self_check_mode}, 8'h00);
        rd(WDOG_ADDR, UVB);
        rd(STAT_ADDR, 8'h01);
        rd(16'h0100, 8'h00);
        ticks(20, 8'h04);
        wr(MISC_ADDR, 8'h01);
        rd(MISC_ADDR, 8'h01);
        chk({7'h00, div40_sel}, 8'h01);
        wr(WDOG_ADDR, 8'h00);
        ticks(40, 8'h01);
        wr(WDOG_ADDR, 8'h00);
        wr(MISC_ADDR, 8'h00);
        test_v <= 1'b1; strap_b <= 1'b1;
        repeat (5) begin
            look(40);
            wr(WDOG_ADDR, 8'hFE);
            chk({7'h00, int_rst}, 8'h00);
        end
        wr(WDOG_ADDR, 8'hFF);                                   // bit 0 high does not feed
        wait_rst(1'b1, TMO + 20);
        wait_rst(1'b0, 50);
        chk({7'h00, self_check_mode}, 8'h01);
        test_v <= 1'b0; strap_b <= 1'b0;
        for (int k = 0; k < 7; k++) begin
            wr(WDOG_ADDR, 8'h00);
            @(posedge ref_clk);
            fetch_valid <= 1'b1; fetch_addr <= ill_a[k];
            @(posedge ref_clk);
            fetch_valid <= 1'b0;
            watch(8);
            chk({7'h00, hits > 0}, {7'h00, ill_e[k]});
            wait_rst(1'b0, 50);
        end
        chk({7'h00, self_check_mode}, 8'h01);
        rst_btn <= 1'b1;
        look(20);
        chk({7'h00, int_rst}, 8'h01);
        rst_btn <= 1'b0;
        wait_rst(1'b0, 200);
        chk({7'h00, self_check_mode}, 8'h00);
        for (int s = 0; s < 2; s++) begin
            wr(MISC_ADDR, 8'(s));
            wr(WDOG_ADDR, 8'h00);
            @(posedge ref_clk);
            wait_exec <= 1'b1;
            @(posedge ref_clk);
            wait_exec <= 1'b0;
            watch(4);
            chk({6'h00, div40_sel, cpu_halt}, 8'h03);
            chk({7'h00, hits > 0}, 8'h01);
            int_req <= 1'b1;
            look(2);
            int_req <= 1'b0;
            look(10);
            chk({6'h00, div40_sel, cpu_halt}, {6'h00, s[0], 1'b0});
        end
        wr(MISC_ADDR, 8'h00);
        wr(WDOG_ADDR, 8'h00);
        @(posedge ref_clk);
        wait_exec <= 1'b1;
        @(posedge ref_clk);
        wait_exec <= 1'b0;
        wait_rst(1'b1, TMO + 20);
        wait_rst(1'b0, 50);
        wr(WDOG_ADDR, 8'h00);
        @(posedge ref_clk);
        stop_exec <= 1'b1;
        @(posedge ref_clk);
        stop_exec <= 1'b0;
        watch(5);
        chk({7'h00, osc_enable}, 8'h00);
        chk(8'(clrs), 8'h01);
        chk({7'h00, hits > 0}, 8'h01);
        look(200);
        chk({7'h00, int_rst}, 8'h00);
        int_req <= 1'b1;
        look(2);
        int_req <= 1'b0;
        look(10);
        chk({7'h00, osc_enable}, 8'h00);
        irq_btn <= 1'b1;
        look(12);
        irq_btn <= 1'b0;
        chk({7'h00, osc_enable}, 8'h01);
        wait_rst(1'b1, TMO + 60);
        wait_rst(1'b0, 5000);
        wr(WDOG_ADDR, 8'h00);
        @(posedge ref_clk);
        stop_exec <= 1'b1;
        @(posedge ref_clk);
        stop_exec <= 1'b0;
        look(20);
        rst_btn <= 1'b1;
        look(20);
        rst_btn <= 1'b0;
        look(3000);
        chk({7'h00, int_rst}, 8'h01);
        wait_rst(1'b0, 2000);
        look(TMO - 24);
        chk({7'h00, int_rst}, 8'h00);
        end_sim();
    end
endmodule // test_rwlpc_top
`default_nettype wire
